/* edctl_pkg.sv */
// Constants, field positions and state codes for the extended device control block
package edctl_pkg;
    localparam logic [31:0] EXT_CTRL_OFFSET = 32'h0000_0018;
    localparam logic [31:0] EXT_CTRL_RESET  = 32'h0010_0000;
    localparam logic [31:0] STORE_MASK      = 32'hB9FB_C000;
    localparam logic [31:0] NVM_MASK        = 32'h00F9_4000;
    localparam int          BIT_SPD_DET     = 12;
    localparam int          BIT_NVM_RLD     = 13;
    localparam int          BIT_SPD_BYP     = 15;
    localparam int          BIT_RELAXED_ORDER_DISABLE      = 17;
    localparam int          BIT_CLK_GATE    = 19;
    localparam int          BIT_PHY_LP      = 20;
    localparam int          BIT_LS_FLOW     = 22;
    localparam int          BIT_LS          = 23;
    localparam int          BIT_EXT_IRQ_AUTO_MASK_ENABLE       = 24;
    localparam int          BIT_IRQ_ACK_AUTO_MASK_ENABLE        = 27;
    localparam int          BIT_DRIVER_LOADED_FLAG    = 28;
    localparam int          BIT_TMR_CLR     = 29;
    localparam int          BIT_PBA         = 31;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} edctl_wr_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} edctl_rd_t;
endpackage

/* edctl_trig.sv */
// Self-clearing trigger held as a request until the consumer accepts it
`timescale 1ns/100ps
module edctl_trig (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic ack,
    output logic      req
);
    logic req_r;
    logic req_nxt;

    always_comb begin
        // New start wins over a same-cycle accept
        req_nxt = start | (req_r & ~ack);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
        end
    end

    assign req = req_r;

    a_trig_holds : assert property (@(posedge clk) disable iff (!rst_n)
        req_r && !ack |=> req_r) else $error("trigger dropped before accept");
    a_trig_clears : assert property (@(posedge clk) disable iff (!rst_n)
        req_r && ack && !start |=> !req_r) else $error("trigger not cleared");
endmodule

/* edctl_irqfx.sv */
// Interrupt side effects steered by the extended control bits
`timescale 1ns/100ps
module edctl_irqfx (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic irq_ack_auto_mask_enable,
    input  wire logic ext_irq_auto_mask_enable,
    input  wire logic timer_clr_en,
    input  wire logic pba_en,
    input  wire logic icr_access,
    input  wire logic msix_fire,
    input  wire logic ext_irq_cause_register_read,
    input  wire logic ims_clear,
    input  wire logic ims_ext_set,
    output logic      imc_load,
    output logic      ext_mask_fire,
    output logic      ext_mask_read,
    output logic      timer_clear,
    output logic      pba_clear
);
    logic [4:0] fx_r;
    logic [4:0] fx_nxt;

    always_comb begin
        fx_nxt[0] = icr_access & irq_ack_auto_mask_enable;
        fx_nxt[1] = msix_fire & ext_irq_auto_mask_enable;
        fx_nxt[2] = ext_irq_cause_register_read & ~ext_irq_auto_mask_enable;
        fx_nxt[3] = ims_clear & timer_clr_en;
        fx_nxt[4] = ims_ext_set & pba_en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fx_r <= 5'h00;
        end else begin
            fx_r <= fx_nxt;
        end
    end

    assign imc_load      = fx_r[0];
    assign ext_mask_fire = fx_r[1];
    assign ext_mask_read = fx_r[2];
    assign timer_clear   = fx_r[3];
    assign pba_clear     = fx_r[4];

    a_irq_ack_auto_mask_enable_effect : assert property (@(posedge clk) disable iff (!rst_n)
        imc_load == $past(icr_access && irq_ack_auto_mask_enable)) else $error("auto-mask copy wrong");
    a_ext_irq_auto_mask_enable_path : assert property (@(posedge clk) disable iff (!rst_n)
        ext_irq_cause_register_read && !ext_irq_auto_mask_enable |=> ext_mask_read && !ext_mask_fire)
        else $error("extended auto-mask path wrong");
    a_timer_clear : assert property (@(posedge clk) disable iff (!rst_n)
        ims_clear |=> timer_clear == $past(timer_clr_en)) else $error("timer clear wrong");
    a_pba_clear : assert property (@(posedge clk) disable iff (!rst_n)
        ims_ext_set && !pba_en |=> !pba_clear) else $error("pending bit cleared in legacy");
endmodule

/* edctl_top.sv */
// Extended device control register with AXI4-Lite access and control outputs
`timescale 1ns/100ps
module edctl_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    input  wire logic              NVM_LOAD_VALID,
    input  wire logic [31:0]       NVM_LOAD_DATA,
    output logic                   NVM_RELOAD_REQ,
    input  wire logic              NVM_RELOAD_ACK,
    output logic                   CFG_BAR_HOLD,
    output logic                   SPD_DETECT_REQ,
    input  wire logic              SPD_DETECT_ACK,
    output logic                   SPEED_BYPASS,
    input  wire logic              PCIE_RO_ENABLE,
    output logic                   RELAXED_ORDER_ALLOW,
    output logic                   CLK_GATE_EN,
    output logic                   PHY_LOW_POWER_EN,
    output logic                   TX_LARGE_SEND_FLOW,
    output logic                   TX_LARGE_SEND,
    input  wire logic              PCIE_SOFT_RST,
    output logic                   DRIVER_LOADED,
    input  wire logic              ICR_ACCESS,
    input  wire logic              MSIX_FIRE,
    input  wire logic              EXT_IRQ_CAUSE_REGISTER_READ,
    input  wire logic              IMS_CLEAR,
    input  wire logic              IMS_EXT_SET,
    output logic                   IMC_LOAD_AUTO_MASK,
    output logic                   EXT_MASK_ON_FIRE,
    output logic                   EXT_MASK_ON_READ,
    output logic                   IRQ_TIMER_CLEAR,
    output logic                   PBA_CLEAR
);
    edctl_pkg::edctl_wr_t wst_r;
    edctl_pkg::edctl_wr_t wst_nxt;
    edctl_pkg::edctl_rd_t rst_r;
    edctl_pkg::edctl_rd_t rst_nxt;
    logic [ADDR_W-1:0]    awaddr_r;
    logic [ADDR_W-1:0]    awaddr_nxt;
    logic [31:0]          wdata_r;
    logic [31:0]          wdata_nxt;
    logic [3:0]           wstrb_r;
    logic [3:0]           wstrb_nxt;
    logic                 aw_got_r;
    logic                 aw_got_nxt;
    logic                 w_got_r;
    logic                 w_got_nxt;
    logic                 awready_r;
    logic                 awready_nxt;
    logic                 wready_r;
    logic                 wready_nxt;
    logic                 bvalid_r;
    logic                 bvalid_nxt;
    logic [1:0]           bresp_r;
    logic [1:0]           bresp_nxt;
    logic                 arready_r;
    logic                 arready_nxt;
    logic                 rvalid_r;
    logic                 rvalid_nxt;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    logic [1:0]           rresp_r;
    logic [1:0]           rresp_nxt;
    logic [31:0]          ctrl_r;
    logic [31:0]          ctrl_nxt;
    logic                 bar_hold_r;
    logic                 bar_hold_nxt;
    logic                 ro_allow_r;
    logic                 ro_allow_nxt;
    logic                 aw_hs;
    logic                 w_hs;
    logic                 commit;
    logic                 wr_hit;
    logic                 spd_start;
    logic                 nvm_start;
    logic                 spd_req;
    logic                 nvm_req;
    logic [31:0]          wmask;
    logic [31:0]          rd_view;

    // Byte enables widened to a bit mask
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wmask[lane*8 +: 8] = {8{wstrb_nxt[lane]}};
        end
    endgenerate

    assign aw_hs  = S_AXI_AWVALID & awready_r;
    assign w_hs   = S_AXI_WVALID & wready_r;
    assign wr_hit = awaddr_nxt[ADDR_W-1:2] == (ADDR_W-2)'(edctl_pkg::EXT_CTRL_OFFSET >> 2);

    always_comb begin
        wst_nxt    = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = aw_hs ? S_AXI_AWADDR : awaddr_r;
        wdata_nxt  = w_hs ? S_AXI_WDATA : wdata_r;
        wstrb_nxt  = w_hs ? S_AXI_WSTRB : wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        commit     = 1'b0;
        case (wst_r)
            edctl_pkg::WR_IDLE: begin
                // Address and data may arrive in either order
                aw_got_nxt = aw_got_r | aw_hs;
                w_got_nxt  = w_got_r | w_hs;
                if (aw_got_nxt && w_got_nxt) begin
                    commit     = 1'b1;
                    aw_got_nxt = 1'b0;
                    w_got_nxt  = 1'b0;
                    bvalid_nxt = 1'b1;
                    bresp_nxt  = wr_hit ? edctl_pkg::RESP_OKAY : edctl_pkg::RESP_SLVERR;
                    wst_nxt    = edctl_pkg::WR_RESP;
                end
            end
            edctl_pkg::WR_RESP: begin
                if (S_AXI_BREADY) begin
                    bvalid_nxt = 1'b0;
                    wst_nxt    = edctl_pkg::WR_IDLE;
                end
            end
            default: begin
                wst_nxt = edctl_pkg::WR_IDLE;
            end
        endcase
        awready_nxt = (wst_nxt == edctl_pkg::WR_IDLE) & ~aw_got_nxt;
        wready_nxt  = (wst_nxt == edctl_pkg::WR_IDLE) & ~w_got_nxt;
    end

    assign spd_start = commit & wr_hit & wmask[edctl_pkg::BIT_SPD_DET]
                     & wdata_nxt[edctl_pkg::BIT_SPD_DET];
    assign nvm_start = commit & wr_hit & wmask[edctl_pkg::BIT_NVM_RLD]
                     & wdata_nxt[edctl_pkg::BIT_NVM_RLD];

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (commit && wr_hit) begin
            // Bit 30 and other reserved bits are never stored
            ctrl_nxt = (ctrl_r & ~(edctl_pkg::STORE_MASK & wmask))
                     | (wdata_nxt & edctl_pkg::STORE_MASK & wmask);
        end
        if (PCIE_SOFT_RST) begin
            ctrl_nxt[edctl_pkg::BIT_DRIVER_LOADED_FLAG] = 1'b0;
        end
        // NVM image wins over a same-cycle software write
        if (NVM_LOAD_VALID) begin
            ctrl_nxt = (ctrl_nxt & ~edctl_pkg::NVM_MASK)
                     | (NVM_LOAD_DATA & edctl_pkg::NVM_MASK);
        end
        // Held until the next full reset, which stands for the reboot
        bar_hold_nxt = bar_hold_r | nvm_start;
        ro_allow_nxt = ~ctrl_r[edctl_pkg::BIT_RELAXED_ORDER_DISABLE] & PCIE_RO_ENABLE;
    end

    always_comb begin
        rd_view = ctrl_r & edctl_pkg::STORE_MASK;
        rd_view[edctl_pkg::BIT_SPD_DET] = spd_req;
        rd_view[edctl_pkg::BIT_NVM_RLD] = nvm_req;
        rst_nxt    = rst_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        case (rst_r)
            edctl_pkg::RD_IDLE: begin
                if (S_AXI_ARVALID && arready_r) begin
                    rvalid_nxt = 1'b1;
                    rst_nxt    = edctl_pkg::RD_DATA;
                    if (S_AXI_ARADDR[ADDR_W-1:2]
                        == (ADDR_W-2)'(edctl_pkg::EXT_CTRL_OFFSET >> 2)) begin
                        rdata_nxt = rd_view;
                        rresp_nxt = edctl_pkg::RESP_OKAY;
                    end else begin
                        rdata_nxt = 32'h0000_0000;
                        rresp_nxt = edctl_pkg::RESP_SLVERR;
                    end
                end
            end
            edctl_pkg::RD_DATA: begin
                if (S_AXI_RREADY) begin
                    rvalid_nxt = 1'b0;
                    rst_nxt    = edctl_pkg::RD_IDLE;
                end
            end
            default: begin
                rst_nxt = edctl_pkg::RD_IDLE;
            end
        endcase
        arready_nxt = rst_nxt == edctl_pkg::RD_IDLE;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wst_r      <= edctl_pkg::WR_IDLE;
            rst_r      <= edctl_pkg::RD_IDLE;
            awaddr_r   <= '0;
            wdata_r    <= 32'h0000_0000;
            wstrb_r    <= 4'h0;
            aw_got_r   <= 1'b0;
            w_got_r    <= 1'b0;
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= edctl_pkg::RESP_OKAY;
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            rresp_r    <= edctl_pkg::RESP_OKAY;
            ctrl_r     <= edctl_pkg::EXT_CTRL_RESET;
            bar_hold_r <= 1'b0;
            ro_allow_r <= 1'b0;
        end else begin
            wst_r      <= wst_nxt;
            rst_r      <= rst_nxt;
            awaddr_r   <= awaddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb_r    <= wstrb_nxt;
            aw_got_r   <= aw_got_nxt;
            w_got_r    <= w_got_nxt;
            awready_r  <= awready_nxt;
            wready_r   <= wready_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            arready_r  <= arready_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            ctrl_r     <= ctrl_nxt;
            bar_hold_r <= bar_hold_nxt;
            ro_allow_r <= ro_allow_nxt;
        end
    end

    edctl_trig u_spd_trig (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .start (spd_start),
        .ack   (SPD_DETECT_ACK),
        .req   (spd_req)
    );

    edctl_trig u_nvm_trig (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .start (nvm_start),
        .ack   (NVM_RELOAD_ACK),
        .req   (nvm_req)
    );

    edctl_irqfx u_irqfx (
        .clk           (REF_CLK),
        .rst_n         (RSTN),
        .irq_ack_auto_mask_enable          (ctrl_r[edctl_pkg::BIT_IRQ_ACK_AUTO_MASK_ENABLE]),
        .ext_irq_auto_mask_enable         (ctrl_r[edctl_pkg::BIT_EXT_IRQ_AUTO_MASK_ENABLE]),
        .timer_clr_en  (ctrl_r[edctl_pkg::BIT_TMR_CLR]),
        .pba_en        (ctrl_r[edctl_pkg::BIT_PBA]),
        .icr_access    (ICR_ACCESS),
        .msix_fire     (MSIX_FIRE),
        .ext_irq_cause_register_read     (EXT_IRQ_CAUSE_REGISTER_READ),
        .ims_clear     (IMS_CLEAR),
        .ims_ext_set   (IMS_EXT_SET),
        .imc_load      (IMC_LOAD_AUTO_MASK),
        .ext_mask_fire (EXT_MASK_ON_FIRE),
        .ext_mask_read (EXT_MASK_ON_READ),
        .timer_clear   (IRQ_TIMER_CLEAR),
        .pba_clear     (PBA_CLEAR)
    );

    assign S_AXI_AWREADY       = awready_r;
    assign S_AXI_WREADY        = wready_r;
    assign S_AXI_BVALID        = bvalid_r;
    assign S_AXI_BRESP         = bresp_r;
    assign S_AXI_ARREADY       = arready_r;
    assign S_AXI_RVALID        = rvalid_r;
    assign S_AXI_RDATA         = rdata_r;
    assign S_AXI_RRESP         = rresp_r;
    assign SPD_DETECT_REQ      = spd_req;
    assign NVM_RELOAD_REQ      = nvm_req;
    assign CFG_BAR_HOLD        = bar_hold_r;
    // Speed taken straight from the forced setting, no switch delay
    assign SPEED_BYPASS        = ctrl_r[edctl_pkg::BIT_SPD_BYP];
    assign RELAXED_ORDER_ALLOW = ro_allow_r;
    assign CLK_GATE_EN         = ctrl_r[edctl_pkg::BIT_CLK_GATE];
    assign PHY_LOW_POWER_EN    = ctrl_r[edctl_pkg::BIT_PHY_LP];
    assign TX_LARGE_SEND_FLOW  = ctrl_r[edctl_pkg::BIT_LS_FLOW];
    assign TX_LARGE_SEND       = ctrl_r[edctl_pkg::BIT_LS];
    assign DRIVER_LOADED       = ctrl_r[edctl_pkg::BIT_DRIVER_LOADED_FLAG];

    a_spd_start : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        spd_start |=> SPD_DETECT_REQ) else $error("speed detect not started");
    a_nvm_start : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        nvm_start |=> NVM_RELOAD_REQ && CFG_BAR_HOLD) else $error("reload not started");
    a_bar_hold : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        CFG_BAR_HOLD |=> CFG_BAR_HOLD) else $error("base address hold released");
    a_ro_never : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        RELAXED_ORDER_ALLOW |-> $past(!ctrl_r[edctl_pkg::BIT_RELAXED_ORDER_DISABLE] && PCIE_RO_ENABLE))
        else $error("relaxed ordering while disabled");
    a_drv_soft : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        PCIE_SOFT_RST |=> !DRIVER_LOADED) else $error("driver flag kept on soft reset");
    a_nvm_load : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        NVM_LOAD_VALID |=> (ctrl_r & edctl_pkg::NVM_MASK)
                           == ($past(NVM_LOAD_DATA) & edctl_pkg::NVM_MASK))
        else $error("NVM fields not loaded");
    a_rsv_zero : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        S_AXI_RVALID |-> !S_AXI_RDATA[30]) else $error("bit 30 read as one");
    a_write_resp : assert property (@(posedge REF_CLK) disable iff (!RSTN)
        commit |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write response missing");

    c_write_hit : cover property (@(posedge REF_CLK) disable iff (!RSTN)
        commit && wr_hit);
    c_spd_done : cover property (@(posedge REF_CLK) disable iff (!RSTN)
        SPD_DETECT_REQ ##[1:20] !SPD_DETECT_REQ);
    c_nvm_reload : cover property (@(posedge REF_CLK) disable iff (!RSTN)
        NVM_RELOAD_REQ ##[1:50] NVM_LOAD_VALID);
    c_read_back : cover property (@(posedge REF_CLK) disable iff (!RSTN)
        S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == edctl_pkg::RESP_OKAY);
endmodule

/* testbench.sv */
// Self-checking testbench for the extended device control register
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic [31:0] nvm_data = 32'h0000_0000;
    logic        nvm_v = 1'b0, ro_en = 1'b0, soft_rst = 1'b0;
    logic [1:0]  ack = 2'h0;
    logic [4:0]  ev = 5'h00;
    logic        awr, wrdy, bv, arr, rv, bar_hold, ro_ok;
    logic [1:0]  bresp, rresp, req;
    logic [31:0] rdata;
    logic [4:0]  fx;
    logic [5:0]  outs;
    int          mismatches = 0, total_checks = 0, cycles = 0;

    edctl_top #(.ADDR_W(8)) u_dut (
        .REF_CLK(clk), .RSTN(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .NVM_LOAD_VALID(nvm_v), .NVM_LOAD_DATA(nvm_data), .NVM_RELOAD_REQ(req[1]),
        .NVM_RELOAD_ACK(ack[1]), .CFG_BAR_HOLD(bar_hold), .SPD_DETECT_REQ(req[0]),
        .SPD_DETECT_ACK(ack[0]), .SPEED_BYPASS(outs[0]), .PCIE_RO_ENABLE(ro_en),
        .RELAXED_ORDER_ALLOW(ro_ok), .CLK_GATE_EN(outs[1]), .PHY_LOW_POWER_EN(outs[2]),
        .TX_LARGE_SEND_FLOW(outs[3]), .TX_LARGE_SEND(outs[4]), .PCIE_SOFT_RST(soft_rst),
        .DRIVER_LOADED(outs[5]), .ICR_ACCESS(ev[0]), .MSIX_FIRE(ev[1]), .EXT_IRQ_CAUSE_REGISTER_READ(ev[2]),
        .IMS_CLEAR(ev[3]), .IMS_EXT_SET(ev[4]), .IMC_LOAD_AUTO_MASK(fx[0]),
        .EXT_MASK_ON_FIRE(fx[1]), .EXT_MASK_ON_READ(fx[2]), .IRQ_TIMER_CLEAR(fx[3]),
        .PBA_CLEAR(fx[4])
    );

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("Checks %0d, mismatch count %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wreg(input logic [31:0] d);
        logic [1:0] r;
        wr(edctl_pkg::EXT_CTRL_OFFSET[7:0], d, r);
        chk("bresp", 32'h0000_0000, 32'(r));
    endtask

    task automatic rreg(input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(edctl_pkg::EXT_CTRL_OFFSET[7:0], d, r);
        chk("rresp", 32'h0000_0000, 32'(r));
        chk("rdata", exp, d);
    endtask

    // Pulse inputs last one cycle; result is looked at after the next edge
    task automatic nvm_load(input logic [31:0] d);
        @(posedge clk);
        nvm_data <= d;
        nvm_v    <= 1'b1;
        @(posedge clk);
        nvm_v <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        rreg(32'h0010_0000);
        chk("outs", 32'h0000_0004, 32'(outs));
        nvm_load(32'hFF68_7000);
        chk("req", 32'h0000_0000, 32'(req));
        rreg(32'h0068_4000);
        chk("outs", 32'h0000_000A, 32'(outs));
        $display("test reset done");
    endtask

    task automatic t_fields();
        logic [31:0] d;
        logic [1:0]  r;
        wreg(32'hFFFF_CFFF);
        rreg(32'hB9FB_C000);
        chk("outs", 32'h0000_003F, 32'(outs));
        wr(8'h1C, 32'h0000_0000, r);
        chk("bresp", 32'h0000_0002, 32'(r));
        rd(8'h1C, d, r);
        chk("rresp", 32'h0000_0002, 32'(r));
        chk("rdata", 32'h0000_0000, d);
        rreg(32'hB9FB_C000);
        // Only lane 2 enabled: the other bytes must keep their value
        wstrb <= 4'h4;
        wreg(32'h0000_0000);
        rreg(32'hB900_C000);
        wstrb <= 4'hF;
        wreg(32'h0000_0000);
        chk("outs", 32'h0000_0000, 32'(outs));
        $display("test fields done");
    endtask

    task automatic t_trig();
        chk("bar_hold", 32'h0000_0000, 32'(bar_hold));
        for (int b = 0; b < 2; b++) begin
            wreg(32'h0000_1000 << b);
            chk("req", 32'h0000_0001 << b, 32'(req));
            rreg(32'h0000_1000 << b);
            @(posedge clk);
            ack <= 2'h1 << b;
            @(posedge clk);
            ack <= 2'h0;
            @(posedge clk);
            #1;
            chk("req", 32'h0000_0000, 32'(req));
            rreg(32'h0000_0000);
        end
        chk("bar_hold", 32'h0000_0001, 32'(bar_hold));
        wreg(32'hFFFF_CFFF);
        nvm_load(32'h0000_0000);
        rreg(32'hB902_8000);
        wreg(32'hFFFF_CFFF);
        rreg(32'hB9FB_C000);
        wreg(32'h0000_0000);
        $display("test triggers done");
    endtask

    task automatic t_ro();
        for (int i = 0; i < 4; i++) begin
            wreg(i[1] ? 32'h0002_0000 : 32'h0000_0000);
            ro_en <= i[0];
            repeat (2) @(posedge clk);
            #1;
            chk("ro_ok", 32'(i == 1), 32'(ro_ok));
        end
        $display("test relaxed order done");
    endtask

    // Bit 24 swaps which auto-mask event is passed on, so both settings are run
    task automatic t_irq();
        for (int en = 0; en < 2; en++) begin
            wreg(en ? 32'hB900_0000 : 32'h0000_0000);
            for (int i = 0; i < 5; i++) begin
                @(posedge clk);
                ev <= 5'h01 << i;
                @(posedge clk);
                ev <= 5'h00;
                #1;
                chk("fx", 32'((5'h01 << i) & (en ? 5'h1B : 5'h04)), 32'(fx));
                @(posedge clk);
                #1;
                chk("fx", 32'h0000_0000, 32'(fx));
            end
        end
        $display("test interrupt steering done");
    endtask

    task automatic t_drv();
        wreg(32'h1000_0000);
        chk("drv", 32'h0000_0020, 32'(outs));
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("drv", 32'h0000_0000, 32'(outs));
        rreg(32'h0000_0000);
        $display("test driver flag done");
    endtask

    // Whole run takes about 160 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_fields();
        t_trig();
        t_ro();
        t_irq();
        t_drv();
        stop_test();
    end
endmodule
